// ==== rtl/wup_pkg.sv ====
// Constants, states and packet layout for the wireless serial pipe.
package wup_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD = 9600;
	localparam int BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int FLUSH_MS = 15;
	localparam int FLUSH_CYC = FLUSH_MS * CYC_PER_MS;
	localparam int HOLD_MS = 20;
	localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
	localparam int DIP_MS = 1;
	localparam int DIP_CYC = DIP_MS * CYC_PER_MS;
	localparam int DIP_PERIOD_MS = 14;
	localparam int DIP_PERIOD_CYC = DIP_PERIOD_MS * CYC_PER_MS;
	localparam int PKT_BYTES = 12;
	localparam int LEN_W = 4;
	localparam int TMR_W = 24;
	localparam logic [2:0] DATA_LAST = 3'h7;
	localparam logic [3:0] STOP_IDX = 4'h9;
	localparam logic [LEN_W-1:0] PKT_FULL = 4'hC;

	typedef enum logic [1:0] {
		WUP_RX_IDLE = 2'h0,
		WUP_RX_START = 2'h1,
		WUP_RX_DATA = 2'h3,
		WUP_RX_STOP = 2'h2
	} wup_rx_st_t;

	typedef struct packed {
		logic sw;
		logic [LEN_W-1:0] len;
		logic [PKT_BYTES*8-1:0] data;
	} wup_pkt_t;
endpackage

// ==== rtl/wup_pipe.sv ====
// Serial pipe and switch line logic of the radio module.
// What this block does
// - Transmit-data is an input of bytes to send, receive-data an output.
// - Data pins use 9600 baud, eight data bits, one stop bit, no parity.
// - No parity is checked; a character passes unchanged unless its stop bit is broken or it meets a full buffer still waiting on the radio.
// - The radio never transmits and receives at the same time.
// - Transmission wins, so nothing is received while input streams in.
// - The radio stays powered and listening whenever it is not transmitting.
// - The switch line is an input except while a remote high is reproduced.
// - A high switch line starts transmission even with no serial bytes.
// - Transmission goes on as long as the switch line is held high.
// - A received high packet makes the switch line an output driven high.
// - The drive ends after 20 ms without new data or at once on a low packet.
// - The switch state travels in the packet header, not as a payload byte.
// - While driving, the line is released for 1 ms in about every 14 ms.
// - A packet goes out at twelve bytes or 15 ms after its first byte.
// - Received bytes leave back to back at line rate.
module wup_pipe #(
	parameter int unsigned BIT_CYC = wup_pkg::BIT_CYC,
	parameter int unsigned FLUSH_CYC = wup_pkg::FLUSH_CYC,
	parameter int unsigned HOLD_CYC = wup_pkg::HOLD_CYC,
	parameter int unsigned DIP_CYC = wup_pkg::DIP_CYC,
	parameter int unsigned DIP_PERIOD_CYC = wup_pkg::DIP_PERIOD_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic txd_i,
	output logic rxd_o,
	input wire logic sw_i,
	output logic sw_o,
	output logic sw_oe_b_o,
	output wup_pkg::wup_pkt_t rf_tx_pkt_o,
	output logic rf_tx_valid_o,
	input wire logic rf_tx_ready_i,
	input wire wup_pkg::wup_pkt_t rf_rx_pkt_i,
	input wire logic rf_rx_valid_i,
	output logic rf_rx_ready_o,
	output logic rf_rx_en_o
);
	localparam int TW = wup_pkg::TMR_W;
	localparam int LW = wup_pkg::LEN_W;

	wup_pkg::wup_rx_st_t srx_st, next_srx_st;
	logic [TW-1:0] srx_cnt, next_srx_cnt;
	logic [2:0] srx_bit, next_srx_bit;
	logic [7:0] srx_sh, next_srx_sh;
	logic byte_stb;

	// Start bit is checked again at mid-bit so a glitch is not a frame.
	always_comb begin
		next_srx_st = srx_st;
		next_srx_cnt = srx_cnt;
		next_srx_bit = srx_bit;
		next_srx_sh = srx_sh;
		byte_stb = 1'b0;
		if (srx_cnt != '0) begin
			next_srx_cnt = srx_cnt - TW'(1);
		end
		case (srx_st)
			wup_pkg::WUP_RX_IDLE: if (!txd_i) begin
				next_srx_st = wup_pkg::WUP_RX_START;
				next_srx_cnt = TW'(BIT_CYC / 2);
			end
			wup_pkg::WUP_RX_START: if (srx_cnt == '0) begin
				next_srx_st = txd_i ? wup_pkg::WUP_RX_IDLE :
					wup_pkg::WUP_RX_DATA;
				next_srx_cnt = TW'(BIT_CYC - 1);
				next_srx_bit = '0;
			end
			wup_pkg::WUP_RX_DATA: if (srx_cnt == '0) begin
				next_srx_sh = {txd_i, srx_sh[7:1]};
				next_srx_cnt = TW'(BIT_CYC - 1);
				next_srx_bit = srx_bit + 3'h1;
				if (srx_bit == wup_pkg::DATA_LAST) begin
					next_srx_st = wup_pkg::WUP_RX_STOP;
				end
			end
			wup_pkg::WUP_RX_STOP: if (srx_cnt == '0) begin
				// A broken stop bit drops the byte; parity is never looked at.
				byte_stb = txd_i;
				next_srx_st = wup_pkg::WUP_RX_IDLE;
			end
			default: next_srx_st = wup_pkg::WUP_RX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			srx_st <= wup_pkg::WUP_RX_IDLE;
			srx_cnt <= '0;
			srx_bit <= '0;
			srx_sh <= '0;
		end else if (ce_i) begin
			srx_st <= next_srx_st;
			srx_cnt <= next_srx_cnt;
			srx_bit <= next_srx_bit;
			srx_sh <= next_srx_sh;
		end
	end

	logic [wup_pkg::PKT_BYTES*8-1:0] acc_data, next_acc_data;
	logic [LW-1:0] acc_len, next_acc_len, base_len;
	logic [TW-1:0] flush_cnt, next_flush_cnt, ka_cnt, next_ka_cnt;
	logic sw_sent, next_sw_sent, pend, next_pend, local_hi, go;
	wup_pkg::wup_pkt_t opkt, next_opkt;

	// Our own drive must not look like a host request, so sample only when
	// the pin is released.
	assign local_hi = sw_i & sw_oe_b_o;

	always_comb begin
		next_acc_data = acc_data;
		next_acc_len = acc_len;
		next_flush_cnt = flush_cnt;
		next_ka_cnt = ka_cnt;
		next_sw_sent = sw_sent;
		next_pend = pend;
		next_opkt = opkt;
		if (flush_cnt != '0) begin
			next_flush_cnt = flush_cnt - TW'(1);
		end
		if (ka_cnt != '0) begin
			next_ka_cnt = ka_cnt - TW'(1);
		end
		if (pend && rf_tx_ready_i) begin
			next_pend = 1'b0;
		end
		go = !pend && ((acc_len == wup_pkg::PKT_FULL) ||
			(acc_len != '0 && flush_cnt == '0) ||
			(local_hi != sw_sent) ||
			(local_hi && ka_cnt == '0));
		if (go) begin
			next_opkt.sw = local_hi;
			next_opkt.len = acc_len;
			next_opkt.data = acc_data;
			next_pend = 1'b1;
			next_sw_sent = local_hi;
			next_ka_cnt = TW'(FLUSH_CYC - 1);
			next_acc_len = '0;
		end
		base_len = go ? '0 : acc_len;
		// A byte that meets a full buffer still waiting on the radio is lost.
		if (byte_stb && base_len != wup_pkg::PKT_FULL) begin
			next_acc_data[8*base_len +: 8] = srx_sh;
			next_acc_len = base_len + LW'(1);
			if (base_len == '0) begin
				next_flush_cnt = TW'(FLUSH_CYC - 1);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			acc_data <= '0;
			acc_len <= '0;
			flush_cnt <= '0;
			ka_cnt <= '0;
			sw_sent <= 1'b0;
			pend <= 1'b0;
			opkt <= '0;
		end else if (ce_i) begin
			acc_data <= next_acc_data;
			acc_len <= next_acc_len;
			flush_cnt <= next_flush_cnt;
			ka_cnt <= next_ka_cnt;
			sw_sent <= next_sw_sent;
			pend <= next_pend;
			opkt <= next_opkt;
		end
	end

	assign rf_tx_pkt_o = opkt;
	assign rf_tx_valid_o = pend;
	assign rf_rx_en_o = !pend;

	wup_pkg::wup_pkt_t rpkt, next_rpkt;
	logic [LW-1:0] ridx, next_ridx;
	logic [3:0] obit, next_obit;
	logic [TW-1:0] ocnt, next_ocnt;
	logic [9:0] osh, next_osh;
	logic obusy, next_obusy, ofin, rx_take;

	// Reception waits while serial input is active or still buffered.
	assign rf_rx_ready_o = !pend && srx_st == wup_pkg::WUP_RX_IDLE &&
		acc_len == '0 && !obusy && ridx == rpkt.len;
	assign rx_take = rf_rx_valid_i && rf_rx_ready_o;

	always_comb begin
		next_rpkt = rpkt;
		next_ridx = ridx;
		next_obit = obit;
		next_ocnt = ocnt;
		next_osh = osh;
		next_obusy = obusy;
		ofin = obusy && ocnt == '0 && obit == wup_pkg::STOP_IDX;
		if (ocnt != '0) begin
			next_ocnt = ocnt - TW'(1);
		end else if (obusy) begin
			if (ofin) begin
				next_obusy = 1'b0;
			end else begin
				next_osh = {1'b1, osh[9:1]};
				next_obit = obit + 4'h1;
				next_ocnt = TW'(BIT_CYC - 1);
			end
		end
		if ((!obusy || ofin) && ridx != rpkt.len) begin
			next_osh = {1'b1, rpkt.data[8*ridx +: 8], 1'b0};
			next_obit = '0;
			next_ocnt = TW'(BIT_CYC - 1);
			next_obusy = 1'b1;
			next_ridx = ridx + LW'(1);
		end
		if (rx_take) begin
			next_rpkt = rf_rx_pkt_i;
			next_ridx = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rpkt <= '0;
			ridx <= '0;
			obit <= '0;
			ocnt <= '0;
			osh <= '1;
			obusy <= 1'b0;
		end else if (ce_i) begin
			rpkt <= next_rpkt;
			ridx <= next_ridx;
			obit <= next_obit;
			ocnt <= next_ocnt;
			osh <= next_osh;
			obusy <= next_obusy;
		end
	end

	assign rxd_o = osh[0];

	logic drive, next_drive;
	logic [TW-1:0] hold_cnt, next_hold_cnt, dip_cnt, next_dip_cnt;

	always_comb begin
		next_drive = drive;
		next_hold_cnt = hold_cnt;
		next_dip_cnt = dip_cnt;
		if (hold_cnt != '0) begin
			next_hold_cnt = hold_cnt - TW'(1);
		end
		if (drive) begin
			next_dip_cnt = (dip_cnt == '0) ? TW'(DIP_PERIOD_CYC - 1) :
				dip_cnt - TW'(1);
			if (hold_cnt == '0) begin
				next_drive = 1'b0;
			end
		end
		if (rx_take) begin
			next_drive = rf_rx_pkt_i.sw;
			next_hold_cnt = TW'(HOLD_CYC - 1);
			if (!drive) begin
				next_dip_cnt = TW'(DIP_PERIOD_CYC - 1);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			drive <= 1'b0;
			hold_cnt <= '0;
			dip_cnt <= '0;
		end else if (ce_i) begin
			drive <= next_drive;
			hold_cnt <= next_hold_cnt;
			dip_cnt <= next_dip_cnt;
		end
	end

	assign sw_o = drive;
	assign sw_oe_b_o = !(drive && dip_cnt >= TW'(DIP_CYC));

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	property p_rxd_idle;
		!obusy |-> rxd_o;
	endproperty
	a_rxd_idle: assert property (p_rxd_idle)
		else $error("Receive-data pin not idle high.");

	property p_half_duplex;
		rf_tx_valid_o |-> !rf_rx_en_o && !rf_rx_ready_o;
	endproperty
	a_half_duplex: assert property (p_half_duplex)
		else $error("Radio listens while transmitting.");

	property p_tx_first;
		srx_st != wup_pkg::WUP_RX_IDLE || acc_len != '0 |-> !rf_rx_ready_o;
	endproperty
	a_tx_first: assert property (p_tx_first)
		else $error("Reception accepted during serial input.");

	property p_listen;
		!rf_tx_valid_o |-> rf_rx_en_o;
	endproperty
	a_listen: assert property (p_listen)
		else $error("Radio not listening while idle.");

	property p_sw_input;
		!sw_o |-> sw_oe_b_o;
	endproperty
	a_sw_input: assert property (p_sw_input)
		else $error("Switch line driven without a remote high.");

	property p_sw_start;
		ce_i && !pend && local_hi && !sw_sent |=> rf_tx_valid_o && rf_tx_pkt_o.sw;
	endproperty
	a_sw_start: assert property (p_sw_start)
		else $error("Switch high did not start a packet.");

	property p_remote_hi;
		ce_i && rx_take && rf_rx_pkt_i.sw |=>
			sw_o && sw_oe_b_o == (dip_cnt < TW'(DIP_CYC));
	endproperty
	a_remote_hi: assert property (p_remote_hi)
		else $error("Remote high not reproduced.");

	property p_remote_lo;
		ce_i && rx_take && !rf_rx_pkt_i.sw |=> !sw_o && sw_oe_b_o;
	endproperty
	a_remote_lo: assert property (p_remote_lo)
		else $error("Low packet did not release the line.");

	property p_full_send;
		ce_i && !pend && acc_len == wup_pkg::PKT_FULL |=>
			rf_tx_valid_o && rf_tx_pkt_o.len == wup_pkg::PKT_FULL;
	endproperty
	a_full_send: assert property (p_full_send)
		else $error("Full buffer not sent.");

	property p_back_to_back;
		ce_i && ofin && ridx != rpkt.len |=> !rxd_o && obusy;
	endproperty
	a_back_to_back: assert property (p_back_to_back)
		else $error("Gap between received bytes.");

	property p_dip;
		sw_o && dip_cnt < TW'(DIP_CYC) |-> sw_oe_b_o;
	endproperty
	a_dip: assert property (p_dip)
		else $error("Switch line not released during dip.");

	c_sw_packet: cover property (rf_tx_valid_o && rf_tx_pkt_o.sw);
	c_full_packet: cover property (rf_tx_valid_o &&
		rf_tx_pkt_o.len == wup_pkg::PKT_FULL);
	c_hold_expire: cover property (sw_o ##1 !sw_o && !rx_take);
	c_burst: cover property (ofin && ridx != rpkt.len);
endmodule

// ==== verification/wup_host_model.sv ====
// Host model: serial sender into the pipe and receiver of its output.
module wup_host_model #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk_i,
	input wire logic rxd_i,
	output logic txd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	time rx_t[$];
	initial begin
		txd_o = 1'b1;
	end
	// Start bit, eight data bits LSB first, one stop bit, no parity.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_i);
			txd_o = fr[i];
			repeat (BIT_CYC - 1) @(negedge clk_i);
		end
	endtask
	// Samples mid-bit; start times let the bench see gaps between bytes.
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge rxd_i);
			rx_t.push_back($time);
			repeat (BIT_CYC / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				b[i] = rxd_i;
			end
			repeat (BIT_CYC) @(posedge clk_i);
			rx_q.push_back(b);
		end
	end
endmodule

// ==== verification/wireless_uart_pipe_logic_io_bench.sv ====
// Self-checking bench of the serial pipe and switch line logic.
module wireless_uart_pipe_logic_io_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BC = 8;
	localparam int FL = 2000;
	localparam int HD = 300;
	localparam int DP = 5;
	localparam int DPP = 40;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic host_sw = 1'b0;
	logic tx_ready = 1'b0;
	logic rx_valid = 1'b0;
	logic txd, rxd, sw_o, sw_oe_b, sw_pin, tx_valid, rx_ready, rx_en;
	wup_pkg::wup_pkt_t tx_pkt;
	wup_pkg::wup_pkt_t rx_pkt = '0;
	int error_cnt = 0;
	int compares = 0;
	always #5 clk = ~clk;
	// Host-side one-shot that bridges the drive dips for a steady level.
	int sw_hold = 0;
	always @(negedge clk) begin
		if (sw_pin === 1'b1) begin
			sw_hold <= 2 * DP;
		end else if (sw_hold > 0) begin
			sw_hold <= sw_hold - 1;
		end
	end
	// The module wins the pin while enabled; the host drives it otherwise.
	assign sw_pin = !sw_oe_b ? sw_o : host_sw;
	wup_pipe #(.BIT_CYC(BC), .FLUSH_CYC(FL), .HOLD_CYC(HD), .DIP_CYC(DP),
		.DIP_PERIOD_CYC(DPP)) dut_u (.core_clk_i(clk), .rst_b_i(rst_b),
		.ce_i(ce), .txd_i(txd), .rxd_o(rxd), .sw_i(sw_pin), .sw_o(sw_o),
		.sw_oe_b_o(sw_oe_b), .rf_tx_pkt_o(tx_pkt), .rf_tx_valid_o(tx_valid),
		.rf_tx_ready_i(tx_ready), .rf_rx_pkt_i(rx_pkt),
		.rf_rx_valid_i(rx_valid), .rf_rx_ready_o(rx_ready),
		.rf_rx_en_o(rx_en));
	wup_host_model #(.BIT_CYC(BC)) host_u (.clk_i(clk), .rxd_i(rxd),
		.txd_o(txd));
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_tx(input int lim, output int n);
		n = 0;
		while (tx_valid !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic accept();
		@(negedge clk);
		tx_ready = 1'b1;
		@(negedge clk);
		tx_ready = 1'b0;
		chk(tx_valid, 1'b0);
		chk(rx_en, 1'b1);
	endtask
	task automatic offer(input logic s, input logic [3:0] l,
		input logic [95:0] d);
		int n;
		n = 0;
		@(negedge clk);
		rx_pkt = '{sw: s, len: l, data: d};
		while (rx_ready !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk(rx_ready, 1'b1);
		rx_valid = 1'b1;
		@(negedge clk);
		rx_valid = 1'b0;
	endtask
	task automatic t_full();
		logic [95:0] exp;
		int n;
		for (int i = 0; i < 12; i++) begin
			exp[8*i+:8] = 8'hA5 ^ 8'(i * 19);
			host_u.send_byte(exp[8*i+:8]);
			if (i == 5) chk(rx_ready, 1'b0);
		end
		wait_tx(20, n);
		chk(tx_valid, 1'b1);
		chk(tx_pkt.len, 4'hC);
		chk(tx_pkt.data, exp);
		chk(tx_pkt.sw, 1'b0);
		chk(rx_en, 1'b0);
		chk(rx_ready, 1'b0);
		accept();
		$display("t_full done");
	endtask
	task automatic t_flush();
		int n;
		host_u.send_byte(8'h3C);
		wait_tx(FL + 20, n);
		chk(n >= FL - BC - 4 && n <= FL + 4, 1'b1);
		chk(tx_pkt.len, 4'h1);
		chk(tx_pkt.data[7:0], 8'h3C);
		accept();
		$display("t_flush done");
	endtask
	task automatic t_rx();
		logic [95:0] d;
		d = 96'(24'hC3_5A81);
		host_u.rx_q.delete();
		host_u.rx_t.delete();
		offer(1'b0, 4'h3, d);
		repeat (32 * BC) @(negedge clk);
		chk(host_u.rx_q.size(), 3);
		for (int i = 0; i < 3; i++) begin
			chk(host_u.rx_q[i], d[8*i+:8]);
		end
		for (int i = 0; i < 2; i++) begin
			chk(96'(host_u.rx_t[i+1] - host_u.rx_t[i]), 96'(BC * 100));
		end
		$display("t_rx done");
	endtask
	task automatic t_sw_rx();
		int n;
		offer(1'b1, 4'h0, '0);
		chk({sw_o, sw_oe_b}, 2'h2);
		n = 0;
		while (sw_oe_b === 1'b0 && n < DPP + 5) begin
			@(negedge clk);
			n++;
		end
		chk(n >= DPP - DP - 2 && n <= DPP - DP + 2, 1'b1);
		n = 0;
		while (sw_oe_b === 1'b1 && n < DPP) begin
			@(negedge clk);
			n++;
		end
		chk(n, DP);
		chk(sw_hold != 0, 1'b1);
		repeat (HD - 50) @(negedge clk);
		chk(sw_o, 1'b1);
		repeat (50) @(negedge clk);
		chk({sw_o, sw_oe_b}, 2'h1);
		chk(tx_valid, 1'b0);
		offer(1'b1, 4'h0, '0);
		repeat (10) @(negedge clk);
		offer(1'b0, 4'h0, '0);
		chk({sw_o, sw_oe_b}, 2'h1);
		$display("t_sw_rx done");
	endtask
	// A low enable must freeze the drive and its hold timer.
	task automatic t_freeze();
		offer(1'b1, 4'h0, '0);
		ce = 1'b0;
		repeat (HD + 20) @(negedge clk);
		chk({sw_o, sw_oe_b}, 2'h2);
		ce = 1'b1;
		repeat (HD + 10) @(negedge clk);
		chk({sw_o, sw_oe_b}, 2'h1);
		$display("t_freeze done");
	endtask
	task automatic t_sw_tx();
		int n;
		host_sw = 1'b1;
		wait_tx(20, n);
		chk(tx_valid, 1'b1);
		chk({tx_pkt.sw, tx_pkt.len}, 5'h10);
		chk(sw_oe_b, 1'b1);
		accept();
		wait_tx(FL + 10, n);
		chk(n >= FL - 10, 1'b1);
		chk({tx_pkt.sw, tx_pkt.len}, 5'h10);
		accept();
		host_sw = 1'b0;
		wait_tx(20, n);
		chk({tx_valid, tx_pkt.sw}, 2'h2);
		accept();
		$display("t_sw_tx done");
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Far beyond the few thousand cycles that the tests need.
	initial begin
		#500_000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		chk({rxd, sw_o, sw_oe_b, tx_valid, rx_en}, 5'h15);
		t_full();
		t_flush();
		t_rx();
		t_sw_rx();
		t_freeze();
		t_sw_tx();
		tally_and_finish();
	end
endmodule
